// File: lsr_classify.sv
// Purpose: Classify one access for restart, alteration and alignment
// Assumes: Pure combinational, same clock domain as the caller
// Notes:   Attributes must be valid with the request
`timescale 1ns/1ps
`include "lsr_consts.svh"

module lsr_classify
    import lsr_pkg::*;
(
    input  wire lsr_req_t   req,
    input  wire lsr_attr_t  attr,
    output lsr_class_t      cls
);
    logic is_load;
    logic is_store;
    logic is_multi;
    logic is_string;

    always_comb begin
        // Cache ops fold into plain load or store classes  (see RULE10)
        is_load   = req.kind inside {LSR_KIND_LOAD, LSR_KIND_CACHE_AS_LOAD, LSR_KIND_FP_LOAD,
                                     LSR_KIND_LOAD_MULTI, LSR_KIND_LOAD_STRING};
        is_store  = req.kind inside {LSR_KIND_STORE, LSR_KIND_CACHE_AS_STORE,
                                     LSR_KIND_BLOCK_ZERO, LSR_KIND_STORE_MULTI,
                                     LSR_KIND_STORE_STRING};
        is_multi  = req.kind inside {LSR_KIND_LOAD_MULTI, LSR_KIND_STORE_MULTI};
        is_string = req.kind inside {LSR_KIND_LOAD_STRING, LSR_KIND_STORE_STRING};

        // Protected classes  (see RULE1) (see RULE2)
        cls.protect = req.atomic & (is_store |
                      (is_load & attr.caching_inhibited & attr.guarded));

        // Little-endian nonscalars and unaligned multiples fault;
        // string alignment is left unchecked  (see RULE11) (see RULE15) (see RULE12) (see RULE13)
        cls.align_fault = ((is_multi | is_string) & req.le_mode) |
                          (is_multi & ((req.addr_lo & `LSR_WORD_MASK) != `LSR_ALIGN_OK));

        // State a partial run may leave altered  (see RULE7) (see RULE8) (see RULE9)
        cls.alt.gpr_range_alt        = req.kind inside {LSR_KIND_LOAD_MULTI,
                                                        LSR_KIND_LOAD_STRING};
        cls.alt.mem_alt              = is_store;
        cls.alt.fp_dest_register_alt = (req.kind == LSR_KIND_FP_LOAD);
    end
endmodule // lsr_classify

// File: lsr_consts.svh
// Purpose: Constants for the load/store restart policy block
// Assumes: Included by its bare name from the package, lsr_classify and lsr_restart_ctrl
// Notes:   Widths, alignment masks and reset values as macros
//
// Overview of operation
// RULE1 - Touched atomic store is never aborted; an abort in the same cycle as the first byte still restarts it
// RULE2 - Touched atomic inhibited guarded load never re-executed; an abort in the same cycle as the first byte still restarts it
// RULE3 - Address compare or breakpoint match lifts guarantee
// RULE4 - Other accesses may abort and restart
// RULE5 - Source registers kept intact for re-execution
// RULE6 - Restart points at the aborted instruction
// RULE7 - Aborted multiple/string load may alter registers
// RULE8 - Aborted store or block zero may alter memory
// RULE9 - Aborted fp load may alter destination
// RULE10 - Cache ops classified as loads or stores
// RULE11 - Multiple and string need big-endian mode
// RULE12 - Multiple operands must be word aligned
// RULE13 - String operands accept any alignment
// RULE14 - Software should align operands naturally
// RULE15 - Little-endian multiple/string raise alignment exception
// RULE16 - Non-restartable mark held until completion
`ifndef LSR_CONSTS_SVH
`define LSR_CONSTS_SVH

`define LSR_IP_W         64
`define LSR_IP_RST       64'h0000_0000_0000_0000
`define LSR_WORD_MASK    2'h3
`define LSR_ALIGN_OK     2'h0

`endif

// File: lsr_mem_model.sv
// Purpose: Memory-side model that performs operand bytes for the access
// Assumes: Drives on the falling edge, like the bench
// Notes:   Prompt or slow first byte; region select sets CI and G
`timescale 1ns/1ps

module lsr_mem_model
    import lsr_pkg::*;
(
    input  wire logic  clk,
    input  wire logic  sys_rst,
    input  wire logic  busy,
    input  wire logic  io_region,
    input  wire logic  slow,
    output lsr_attr_t  attr,
    output logic       byte_done
);
    int wait_cnt;

    // I/O region is both inhibited and guarded, memory is neither
    assign attr = '{caching_inhibited: io_region, guarded: io_region};

    // One byte per access, so a partial run is easy to tell apart
    always @(negedge clk or posedge sys_rst) begin
        if (sys_rst || !busy) begin
            wait_cnt  <= 0;
            byte_done <= 1'b0;
        end else begin
            wait_cnt  <= wait_cnt + 1;
            byte_done <= (wait_cnt == (slow ? 3 : 0));
        end
    end
endmodule // lsr_mem_model

// File: lsr_pkg.sv
// Purpose: Types shared by the restart policy block
// Assumes: Constants come from lsr_consts.svh
// Notes:   Kind enum carries no codes
`include "lsr_consts.svh"

package lsr_pkg;

    typedef enum logic [3:0] {
        LSR_KIND_LOAD,
        LSR_KIND_STORE,
        LSR_KIND_CACHE_AS_LOAD,
        LSR_KIND_CACHE_AS_STORE,
        LSR_KIND_BLOCK_ZERO,
        LSR_KIND_FP_LOAD,
        LSR_KIND_LOAD_MULTI,
        LSR_KIND_STORE_MULTI,
        LSR_KIND_LOAD_STRING,
        LSR_KIND_STORE_STRING
    } lsr_kind_t;

    typedef struct packed {
        lsr_kind_t                 kind;
        logic                      atomic;
        logic                      le_mode;
        logic [1:0]                addr_lo;
        logic [`LSR_IP_W-1:0]      ip;
    } lsr_req_t;

    typedef struct packed {
        logic caching_inhibited;
        logic guarded;
    } lsr_attr_t;

    typedef struct packed {
        logic gpr_range_alt;
        logic mem_alt;
        logic fp_dest_register_alt;
    } lsr_alt_t;

    typedef struct packed {
        logic     protect;
        logic     align_fault;
        lsr_alt_t alt;
    } lsr_class_t;

endpackage

// File: lsr_restart_ctrl.sv
// Purpose: Restart decision for one in-flight load or store
// Assumes: Memory subsystem and pipeline share clk; one access at a time
// Notes:   Refused aborts must be retried by recovery after completion
`timescale 1ns/1ps
`include "lsr_consts.svh"

module lsr_restart_ctrl
    import lsr_pkg::*;
(
    input  wire logic                 clk,
    input  wire logic                 sys_rst,
    input  wire logic                 clk_en,
    input  wire logic                 req_valid,
    input  wire lsr_req_t             req,
    input  wire lsr_attr_t            attr,
    input  wire logic                 byte_done,
    input  wire logic                 abort_req,
    input  wire logic                 dac_match,
    input  wire logic                 dabr_match,
    input  wire logic                 complete,
    output logic                      req_ready,
    output logic                      hold_src_regs,
    output logic                      no_restart_ff,
    output logic                      align_exc_ff,
    output logic                      abort_refused_ff,
    output logic                      restart_ff,
    output logic [`LSR_IP_W-1:0]      restart_ip_ff,
    output lsr_alt_t                  alt_ff
);
    // ****************************************************************
    // State
    // ****************************************************************
    typedef enum logic [1:0] {ST_IDLE, ST_ISSUED, ST_TOUCHED} lsr_state_t;

    lsr_state_t               state_ff;
    lsr_state_t               nxt_state;
    lsr_req_t                 req_ff;
    lsr_req_t                 nxt_req;
    lsr_class_t               cls_ff;
    lsr_class_t               nxt_cls;
    lsr_class_t               cls_now;
    logic                     nxt_no_restart;
    logic                     nxt_align_exc;
    logic                     nxt_abort_refused;
    logic                     nxt_restart;
    logic [`LSR_IP_W-1:0]     nxt_restart_ip;
    lsr_alt_t                 nxt_alt;
    logic                     busy;
    logic                     bp_hit;

    lsr_classify u_classify (
        .req  (req),
        .attr (attr),
        .cls  (cls_now)
    );

    assign busy      = (state_ff != ST_IDLE);
    assign bp_hit    = dac_match | dabr_match;
    assign req_ready = (state_ff == ST_IDLE);
    // Address and source registers stay frozen while in flight  (see RULE5)
    assign hold_src_regs = busy;

    // ****************************************************************
    // Next-state logic
    // ****************************************************************
    always_comb begin
        nxt_state         = state_ff;
        nxt_req           = req_ff;
        nxt_cls           = cls_ff;
        nxt_no_restart    = no_restart_ff;
        nxt_align_exc     = 1'b0;
        nxt_abort_refused = 1'b0;
        nxt_restart       = 1'b0;
        nxt_restart_ip    = restart_ip_ff;
        nxt_alt           = alt_ff;
        unique case (state_ff)
            ST_IDLE: begin
                if (req_valid) begin
                    if (cls_now.align_fault) begin
                        // Refused before any byte moves  (see RULE15) (see RULE12)
                        nxt_align_exc = 1'b1;
                    end else begin
                        nxt_state = ST_ISSUED;
                        nxt_req   = req;
                        nxt_cls   = cls_now;
                    end
                end
            end
            ST_ISSUED, ST_TOUCHED: begin
                if (byte_done) begin
                    nxt_state = ST_TOUCHED;
                    // First performed byte locks protected accesses  (see RULE16)
                    if (cls_ff.protect) begin
                        nxt_no_restart = 1'b1;
                    end
                end
                // Debug matches lift the lock  (see RULE3)
                if (bp_hit) begin
                    nxt_no_restart = 1'b0;
                end
                if (complete) begin
                    nxt_state      = ST_IDLE;
                    nxt_no_restart = 1'b0;
                end else if (abort_req) begin
                    if (no_restart_ff && !bp_hit) begin
                        // Lock already taken; abort must wait  (see RULE1) (see RULE2)
                        nxt_abort_refused = 1'b1;
                    end else begin
                        // Restart at the same instruction  (see RULE4) (see RULE6)
                        nxt_state      = ST_IDLE;
                        nxt_restart    = 1'b1;
                        nxt_restart_ip = req_ff.ip;
                        nxt_no_restart = 1'b0;
                        if (state_ff == ST_TOUCHED || byte_done) begin
                            // Report what may already be altered  (see RULE7) (see RULE8) (see RULE9)
                            nxt_alt = cls_ff.alt;
                        end else begin
                            nxt_alt = '0;
                        end
                    end
                end
            end
        endcase
    end

    // ****************************************************************
    // Registers
    // ****************************************************************
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            state_ff         <= ST_IDLE;
            req_ff           <= '0;
            cls_ff           <= '0;
            no_restart_ff    <= 1'b0;
            align_exc_ff     <= 1'b0;
            abort_refused_ff <= 1'b0;
            restart_ff       <= 1'b0;
            restart_ip_ff    <= `LSR_IP_RST;
            alt_ff           <= '0;
        end else if (clk_en) begin
            state_ff         <= nxt_state;
            req_ff           <= nxt_req;
            cls_ff           <= nxt_cls;
            no_restart_ff    <= nxt_no_restart;
            align_exc_ff     <= nxt_align_exc;
            abort_refused_ff <= nxt_abort_refused;
            restart_ff       <= nxt_restart;
            restart_ip_ff    <= nxt_restart_ip;
            alt_ff           <= nxt_alt;
        end
    end

    // ****************************************************************
    // Assertions
    // ****************************************************************
    property p_locked_abort_refused;
        @(posedge clk) disable iff (sys_rst)
        (clk_en && busy && no_restart_ff && abort_req && !complete && !bp_hit)
            |=> (abort_refused_ff && !restart_ff && state_ff != ST_IDLE);
    endproperty
    a_locked_abort_refused: assert property (p_locked_abort_refused) // see RULE1
        else $error("locked access was restarted");

    property p_guarded_load_locks;
        @(posedge clk) disable iff (sys_rst)
        (clk_en && busy && byte_done && cls_ff.protect && !bp_hit && !complete && !abort_req)
            |=> no_restart_ff;
    endproperty
    a_guarded_load_locks: assert property (p_guarded_load_locks) // see RULE2
        else $error("protected access not locked after first byte");

    property p_bp_lifts;
        @(posedge clk) disable iff (sys_rst)
        (clk_en && busy && bp_hit) |=> !no_restart_ff;
    endproperty
    a_bp_lifts: assert property (p_bp_lifts) // see RULE3
        else $error("debug match did not lift lock");

    property p_free_abort_restarts;
        @(posedge clk) disable iff (sys_rst)
        (clk_en && busy && abort_req && !complete && !no_restart_ff)
            |=> (restart_ff && state_ff == ST_IDLE);
    endproperty
    a_free_abort_restarts: assert property (p_free_abort_restarts) // see RULE4
        else $error("restartable abort not restarted");

    property p_restart_ip;
        @(posedge clk) disable iff (sys_rst)
        (clk_en && busy && abort_req && !complete && !no_restart_ff)
            |=> (restart_ip_ff == $past(req_ff.ip));
    endproperty
    a_restart_ip: assert property (p_restart_ip) // see RULE6
        else $error("restart ip is not the aborted instruction");

    property p_le_nonscalar_faults;
        @(posedge clk) disable iff (sys_rst)
        (clk_en && req_ready && req_valid && req.le_mode &&
         req.kind inside {LSR_KIND_LOAD_MULTI, LSR_KIND_STORE_MULTI,
                          LSR_KIND_LOAD_STRING, LSR_KIND_STORE_STRING})
            |=> (align_exc_ff && state_ff == ST_IDLE);
    endproperty
    a_le_nonscalar_faults: assert property (p_le_nonscalar_faults) // see RULE15
        else $error("little-endian nonscalar executed");

    property p_multi_unaligned;
        @(posedge clk) disable iff (sys_rst)
        (clk_en && req_ready && req_valid && req.addr_lo != `LSR_ALIGN_OK &&
         req.kind inside {LSR_KIND_LOAD_MULTI, LSR_KIND_STORE_MULTI})
            |=> align_exc_ff;
    endproperty
    a_multi_unaligned: assert property (p_multi_unaligned) // see RULE12
        else $error("unaligned multiple accepted");

    property p_string_any_align;
        @(posedge clk) disable iff (sys_rst)
        (clk_en && req_ready && req_valid && !req.le_mode &&
         req.kind inside {LSR_KIND_LOAD_STRING, LSR_KIND_STORE_STRING})
            |=> (!align_exc_ff && state_ff == ST_ISSUED);
    endproperty
    a_string_any_align: assert property (p_string_any_align) // see RULE13
        else $error("big-endian string refused");

    property p_lock_held;
        @(posedge clk) disable iff (sys_rst)
        (clk_en && no_restart_ff && !complete && !bp_hit) |=> no_restart_ff;
    endproperty
    a_lock_held: assert property (p_lock_held) // see RULE16
        else $error("lock dropped before completion");

    property p_src_held;
        @(posedge clk) disable iff (sys_rst)
        (clk_en && req_ready && req_valid && !cls_now.align_fault) |=> hold_src_regs;
    endproperty
    a_src_held: assert property (p_src_held) // see RULE5
        else $error("source registers not held for accepted access");

    c_restart:  cover property (@(posedge clk) disable iff (sys_rst) restart_ff);
    c_refused:  cover property (@(posedge clk) disable iff (sys_rst) abort_refused_ff);
    c_align:    cover property (@(posedge clk) disable iff (sys_rst) align_exc_ff);
    c_alt_mem:  cover property (@(posedge clk) disable iff (sys_rst) restart_ff && alt_ff.mem_alt);

endmodule // lsr_restart_ctrl

// File: test_lsr_restart_ctrl.sv
// Purpose: Self-checking bench for the restart decision block
// Assumes: One access at a time; inputs change on the falling edge
// Notes:   Every access without an alignment exception is aborted once; refused ones then complete
`timescale 1ns/1ps

module test_lsr_restart_ctrl
    import lsr_pkg::*;
;
    logic        clk = 1'b0, sys_rst = 1'b1, req_valid = 1'b0, serve = 1'b0, clk_en = 1'b1;
    logic        abort_req = 1'b0, dac_match = 1'b0, dabr_match = 1'b0;
    logic        complete = 1'b0, io_region = 1'b0, slow = 1'b0, byte_done;
    logic        req_ready, hold_src_regs, no_restart_ff, align_exc_ff;
    logic        abort_refused_ff, restart_ff;
    logic [63:0] restart_ip_ff, ip = 64'h0000_0000_0000_1000;
    lsr_req_t    req = '0;
    lsr_attr_t   attr;
    lsr_alt_t    alt_ff;
    int          fails = 0, cmp_count = 0;

    always #50 clk = ~clk;

    lsr_mem_model MEM (.clk(clk), .sys_rst(sys_rst), .busy(hold_src_regs && serve),
        .io_region(io_region), .slow(slow), .attr(attr), .byte_done(byte_done));

    lsr_restart_ctrl DUT (.clk(clk), .sys_rst(sys_rst), .clk_en(clk_en),
        .req_valid(req_valid), .req(req), .attr(attr), .byte_done(byte_done),
        .abort_req(abort_req), .dac_match(dac_match), .dabr_match(dabr_match),
        .complete(complete), .req_ready(req_ready), .hold_src_regs(hold_src_regs),
        .no_restart_ff(no_restart_ff), .align_exc_ff(align_exc_ff),
        .abort_refused_ff(abort_refused_ff), .restart_ff(restart_ff),
        .restart_ip_ff(restart_ip_ff), .alt_ff(alt_ff));

    task automatic wrap_up;
        if (fails == 0 && cmp_count > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask

    task automatic chk(input logic ok, input string msg);
        cmp_count++;
        if (!ok) begin
            fails++;
            $display("wrong value at %0t: %s", $time, msg);
        end
    endtask

    // ****************************************
    // One access: issue, touch, abort, finish
    // ****************************************
    task automatic run(input lsr_kind_t k, input logic at, le, input logic [1:0] lo,
                       input logic io, touch, input logic [1:0] dbg, input logic bad);
        logic     st;
        logic     prot;
        logic     exp_rst;
        lsr_alt_t ea;
        st   = k inside {LSR_KIND_STORE, LSR_KIND_CACHE_AS_STORE, LSR_KIND_BLOCK_ZERO,
                         LSR_KIND_STORE_MULTI, LSR_KIND_STORE_STRING};
        prot = at && (st || io);
        exp_rst = !(prot && touch) || (dbg != 2'h0);
        ea = '{gpr_range_alt: touch && (k inside {LSR_KIND_LOAD_MULTI, LSR_KIND_LOAD_STRING}),
               mem_alt: touch && st, fp_dest_register_alt: touch && k == LSR_KIND_FP_LOAD};
        ip = ip + 64'h0000_0000_0000_0004;
        @(negedge clk);
        io_region = io;
        serve     = touch;
        req       = '{kind: k, atomic: at, le_mode: le, addr_lo: lo, ip: ip};
        req_valid = 1'b1;
        @(negedge clk);
        req_valid = 1'b0;
        chk(align_exc_ff === bad, "alignment exception");
        if (bad)
            return;
        chk(hold_src_regs === 1'b1 && req_ready === 1'b0, "busy");
        if (touch) begin
            for (int i = 0; i < 8 && byte_done !== 1'b1; i++)
                @(posedge clk);
            @(negedge clk);
            chk(no_restart_ff === prot, "lock after byte");
        end
        {dac_match, dabr_match} = dbg;
        abort_req = 1'b1;
        @(negedge clk);
        {abort_req, dac_match, dabr_match} = 3'h0;
        chk(restart_ff === exp_rst, "restart");
        chk(abort_refused_ff === !exp_rst, "refusal");
        if (exp_rst) begin
            chk(restart_ip_ff === ip && req_ready === 1'b1, "restart ip");
            chk(alt_ff === ea, "altered state");
        end else begin
            chk(hold_src_regs === 1'b1 && no_restart_ff === 1'b1, "held");
            clk_en   = 1'b0;
            complete = 1'b1;
            @(negedge clk);
            chk(no_restart_ff === 1'b1 && req_ready === 1'b0, "frozen");
            clk_en   = 1'b1;
            @(negedge clk);
            complete = 1'b0;
            chk(no_restart_ff === 1'b0 && req_ready === 1'b1, "completion");
        end
    endtask

    // ****************************************
    // Test sequence
    // ****************************************
    initial begin
        repeat (4) @(posedge clk);
        @(negedge clk);
        sys_rst = 1'b0;
        run(LSR_KIND_STORE, 0, 0, 0, 0, 1, 0, 0);
        run(LSR_KIND_STORE, 1, 0, 0, 0, 1, 0, 0);
        run(LSR_KIND_STORE, 1, 0, 0, 0, 0, 0, 0);
        run(LSR_KIND_STORE, 1, 0, 0, 0, 1, 2, 0);
        run(LSR_KIND_LOAD, 1, 0, 0, 1, 1, 0, 0);
        run(LSR_KIND_LOAD, 1, 0, 0, 0, 1, 0, 0);
        run(LSR_KIND_LOAD, 1, 0, 0, 1, 1, 1, 0);
        slow = 1'b1;
        run(LSR_KIND_CACHE_AS_STORE, 1, 0, 0, 0, 1, 0, 0);
        run(LSR_KIND_CACHE_AS_LOAD, 1, 0, 0, 1, 1, 0, 0);
        run(LSR_KIND_CACHE_AS_LOAD, 1, 0, 0, 0, 1, 0, 0);
        run(LSR_KIND_BLOCK_ZERO, 0, 0, 0, 0, 1, 0, 0);
        run(LSR_KIND_FP_LOAD, 0, 0, 0, 0, 1, 0, 0);
        run(LSR_KIND_LOAD_MULTI, 0, 0, 0, 0, 1, 0, 0);
        run(LSR_KIND_LOAD_STRING, 0, 0, 3, 0, 1, 0, 0);
        run(LSR_KIND_STORE_STRING, 0, 0, 1, 0, 1, 0, 0);
        slow = 1'b0;
        for (int k = LSR_KIND_LOAD_MULTI; k <= LSR_KIND_STORE_STRING; k++)
            run(lsr_kind_t'(k), 0, 1, 0, 0, 0, 0, 1);
        for (int a = 1; a < 4; a++)
            run(LSR_KIND_STORE_MULTI, 0, 0, 2'(a), 0, 0, 0, 1);
        run(LSR_KIND_STORE_MULTI, 0, 0, 0, 0, 1, 0, 0);
        wrap_up;
    end

    // Whole sequence needs under 200 cycles
    initial begin
        repeat (5000) @(posedge clk);
        fails++;
        wrap_up;
    end
endmodule // test_lsr_restart_ctrl
